// File: rtl/fsp_flash_status.v
// Status word generation and protection logic for the flash controller.
`timescale 1ns/10ps
`include "fsp_consts.vh"
module fsp_flash_status #(
  parameter integer REJECT_CYC = `FSP_REJECT_CYC,
  parameter integer WINDOW_CYC = `FSP_WINDOW_CYC
) (
  input  wire        i_clock,
  input  wire        i_srst,
  input  wire        i_rd,          // Flash read strobe, one cycle.
  input  wire [2:0]  i_rd_block,    // Block of the read address.
  input  wire        i_rd_match,    // Read address equals programmed word.
  input  wire        i_rd_fetch,    // Read is an instruction fetch from flash.
  input  wire [15:0] i_array_data,  // Array data for the read address.
  input  wire        i_prog_start,  // Word program command decoded.
  input  wire [2:0]  i_prog_block,
  input  wire [15:0] i_prog_data,
  input  wire [15:0] i_prog_old,    // Current content of the target word.
  input  wire        i_erase_conf,  // Block erase confirm accepted.
  input  wire [2:0]  i_erase_block,
  input  wire        i_chip_erase,
  input  wire        i_suspend_cmd,
  input  wire        i_resume_cmd,
  input  wire        i_reset_cmd,   // Read/reset instruction.
  input  wire        i_unlock_cmd,  // Temporary unlock command.
  input  wire        i_lock_rd_cmd, // Lock status read command.
  input  wire        i_lock_set,    // Set protection data cycle.
  input  wire [15:0] i_lock_data,
  input  wire        i_op_done,     // Engine finished the running operation.
  input  wire        i_op_fail,     // Engine reports failure with done.
  output reg  [15:0] o_rd_data,
  output reg         o_busy,
  output reg         o_suspended,
  output reg         o_refused
);
  // ------------------------------------------------------------------
  // State and storage
  // ------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PROG = 5'h02;
  localparam [4:0] ST_WIN  = 5'h04;
  localparam [4:0] ST_ERAS = 5'h08;
  localparam [4:0] ST_SUSP = 5'h10;

  reg  [4:0]  state_r;
  reg         sprog_r;      // Program running inside suspend.
  reg  [6:0]  erase_set_r;  // Blocks selected for erase.
  reg  [6:0]  bad_set_r;    // Blocks of a failed erase.
  reg         last_erase_r; // Last finished op was an erase.
  reg  [15:0] prog_word_r;
  reg  [2:0]  prog_blk_r;
  reg         tog_a_r;
  reg         tog_b_r;
  reg         fail_r;
  reg         unlock_r;
  reg         lock_rd_r;
  reg         poll_hi_r;    // Poll bit reads 1 once suspend is entered.
  wire [15:0] lock_act;
  wire [15:0] lock_raw;
  wire        lock_err;
  wire        rej_busy;
  wire        win_done;
  wire        rej_start;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Block number to one-hot set; numbers past the last block give zero.
  function [6:0] blk_hot;
    input [2:0] b;
    begin
      blk_hot = (b < 3'h7) ? (7'h01 << b) : 7'h00;
    end
  endfunction

  // A block may be written when unlocked or under temporary unlock.
  function blk_open;
    input [2:0]  b;
    input [15:0] lw;
    input        tu;
    begin
      blk_open = tu | ((lw[6:0] & blk_hot(b)) != 7'h00) | (b == 3'h7);
    end
  endfunction

  wire prog_ok  = blk_open(i_prog_block, lock_act, unlock_r);
  wire erase_ok = blk_open(i_erase_block, lock_act, unlock_r);
  wire rd_in_er = (erase_set_r & blk_hot(i_rd_block)) != 7'h00;
  wire rd_bad   = (bad_set_r & blk_hot(i_rd_block)) != 7'h00;
  wire prog_err = (~i_prog_old & i_prog_data) != 16'h0000;
  wire prog_hit = (erase_set_r & blk_hot(i_prog_block)) != 7'h00;
  assign rej_start = (i_erase_conf & ~erase_ok & ~i_chip_erase);

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------
  fsp_lock_store u_lock (
    .i_clock    (i_clock),
    .i_srst     (i_srst),
    .i_set_we   (i_lock_set),
    .i_set_data (i_lock_data),
    .o_active   (lock_act),
    .o_stored   (lock_raw),
    .o_set_err  (lock_err)
  );

  fsp_timer #(.CYCLES(REJECT_CYC), .W(16)) u_rej (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_start (rej_start),
    .i_stop  (1'b0),
    .o_busy  (rej_busy),
    .o_done  ()
  );

  fsp_timer #(.CYCLES(WINDOW_CYC), .W(16)) u_win (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_start (i_erase_conf & erase_ok & (state_r != ST_ERAS)),
    .i_stop  (i_suspend_cmd | i_reset_cmd),
    .o_busy  (),
    .o_done  (win_done)
  );

  // ------------------------------------------------------------------
  // Operation state machine
  // ------------------------------------------------------------------
  // Reset cancels unlock and clears every sequence flag.
  always @(posedge i_clock) begin
    if (i_srst) begin
      state_r      <= ST_IDLE;
      sprog_r      <= 1'b0;
      erase_set_r  <= 7'h00;
      bad_set_r    <= 7'h00;
      last_erase_r <= 1'b0;
      prog_word_r  <= 16'hFFFF;
      prog_blk_r   <= 3'h0;
      fail_r       <= 1'b0;
      unlock_r     <= 1'b0;
      lock_rd_r    <= 1'b0;
      poll_hi_r    <= 1'b0;
      o_refused    <= 1'b0;
    end else begin
      o_refused <= (i_prog_start & ~prog_ok) | rej_start;
      if (i_unlock_cmd)
        unlock_r <= 1'b1;
      if (i_lock_rd_cmd)
        lock_rd_r <= 1'b1;
      else if (i_reset_cmd)
        lock_rd_r <= 1'b0;
      // Set wins over clear when a failure lands with the reset command.
      if (i_op_done & i_op_fail | i_prog_start & prog_ok & prog_err
          | lock_err)
        fail_r <= 1'b1;
      else if (i_reset_cmd)
        fail_r <= 1'b0;
      if (i_reset_cmd)
        bad_set_r <= 7'h00;
      case (state_r)
        ST_IDLE: begin
          if (i_prog_start & prog_ok) begin
            state_r     <= ST_PROG;
            prog_word_r <= i_prog_data;
            prog_blk_r  <= i_prog_block;
          end else if (i_erase_conf & erase_ok) begin
            state_r     <= ST_WIN;
            erase_set_r <= i_chip_erase ? 7'h7F : blk_hot(i_erase_block);
            bad_set_r   <= 7'h00;
          end
        end
        ST_PROG: begin
          if (i_op_done | i_reset_cmd) begin
            state_r      <= ST_IDLE;
            last_erase_r <= 1'b0;
          end
        end
        ST_WIN: begin
          if (i_erase_conf & erase_ok)
            erase_set_r <= erase_set_r | blk_hot(i_erase_block);
          if (i_reset_cmd) begin
            state_r     <= ST_IDLE;
            erase_set_r <= 7'h00;
          end else if (i_suspend_cmd) begin
            state_r   <= ST_SUSP;
            poll_hi_r <= 1'b1;
          end else if (win_done) begin
            state_r <= ST_ERAS;
          end
        end
        ST_ERAS: begin
          if (i_reset_cmd) begin
            state_r     <= ST_IDLE;
            erase_set_r <= 7'h00;
          end else if (i_suspend_cmd) begin
            state_r   <= ST_SUSP;
            poll_hi_r <= 1'b1;
          end else if (i_op_done) begin
            state_r      <= ST_IDLE;
            last_erase_r <= 1'b1;
            if (i_op_fail)
              bad_set_r <= erase_set_r;
            erase_set_r  <= 7'h00;
          end
        end
        ST_SUSP: begin
          if (sprog_r) begin
            if (i_op_done)
              sprog_r <= 1'b0;
          end else if (i_reset_cmd) begin
            state_r     <= ST_IDLE;
            erase_set_r <= 7'h00;
            poll_hi_r   <= 1'b0;
          end else if (i_resume_cmd) begin
            state_r   <= ST_ERAS;
            poll_hi_r <= 1'b0;
          end else if (i_prog_start & prog_ok & ~prog_hit) begin
            sprog_r     <= 1'b1;
            prog_word_r <= i_prog_data;
            prog_blk_r  <= i_prog_block;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Toggle bits
  // ------------------------------------------------------------------
  // Toggle A flips per program status read and per erase read past the window, B per erase read past the window and per program aimed at a suspended erase's block;
  // both stop with the operation, except B on reads of a failed erase's blocks.
  always @(posedge i_clock) begin
    if (i_srst) begin
      tog_a_r <= 1'b0;
      tog_b_r <= 1'b0;
    end else begin
      if ((i_rd & (state_r == ST_PROG | state_r == ST_ERAS | sprog_r))
          | ((i_suspend_cmd | i_resume_cmd)
             & (state_r == ST_ERAS | state_r == ST_SUSP)))
        tog_a_r <= ~tog_a_r;
      if ((i_rd & state_r == ST_ERAS)
          | (state_r == ST_SUSP & ((i_rd & rd_in_er)
             | (i_prog_start & prog_hit)))
          | (i_rd & rd_bad & state_r == ST_IDLE))
        tog_b_r <= ~tog_b_r;
    end
  end

  // ------------------------------------------------------------------
  // Read data path
  // ------------------------------------------------------------------
  // Status is given for reads at the programmed word or erased blocks;
  // reads elsewhere during a suspend see the array.
  reg [15:0] st_w;
  reg        st_sel;
  always @* begin
    st_w   = 16'h0000;
    st_sel = 1'b0;
    if (state_r == ST_PROG | sprog_r) begin
      st_sel = ~sprog_r | i_rd_match | rd_in_er;
      st_w[`FSP_POLL_BIT]  = ~prog_word_r[7];
      st_w[`FSP_TOG_A_BIT] = (sprog_r & rd_in_er) | tog_a_r;
      st_w[`FSP_TOG_B_BIT] = sprog_r & i_rd_match ? 1'b1
                             : tog_b_r;
      st_w[`FSP_FAIL_BIT]  = fail_r;
      st_w[`FSP_WIN_BIT]   = 1'b1;
    end else if (state_r == ST_WIN | state_r == ST_ERAS) begin
      st_sel = 1'b1;
      st_w[`FSP_POLL_BIT]  = 1'b0;
      st_w[`FSP_TOG_A_BIT] = tog_a_r;
      st_w[`FSP_TOG_B_BIT] = tog_b_r;
      st_w[`FSP_FAIL_BIT]  = fail_r;
      st_w[`FSP_WIN_BIT]   = (state_r != ST_WIN);
    end else if (state_r == ST_SUSP) begin
      st_sel = rd_in_er;
      st_w[`FSP_POLL_BIT]  = poll_hi_r;
      st_w[`FSP_TOG_A_BIT] = 1'b1;
      st_w[`FSP_TOG_B_BIT] = tog_b_r;
      st_w[`FSP_FAIL_BIT]  = fail_r;
      st_w[`FSP_WIN_BIT]   = 1'b1;
    end else if (rej_busy) begin
      st_sel = 1'b1;
      st_w[`FSP_POLL_BIT]  = 1'b0;
      st_w[`FSP_WIN_BIT]   = 1'b1;
    end else if (fail_r | rd_bad) begin
      st_sel = 1'b1;
      st_w[`FSP_POLL_BIT]  = last_erase_r | prog_word_r[7];
      st_w[`FSP_TOG_A_BIT] = last_erase_r | prog_word_r[6];
      st_w[`FSP_TOG_B_BIT] = tog_b_r;
      st_w[`FSP_FAIL_BIT]  = fail_r;
      st_w[`FSP_WIN_BIT]   = 1'b1;
    end
  end

  // Registered read port; code lock hides data from foreign reads.
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_rd_data   <= 16'h0000;
      o_busy      <= 1'b0;
      o_suspended <= 1'b0;
    end else begin
      o_busy      <= (state_r != ST_IDLE) & (state_r != ST_SUSP) | sprog_r;
      o_suspended <= (state_r == ST_SUSP);
      if (i_rd) begin
        if (lock_rd_r)
          o_rd_data <= lock_raw & `FSP_LOCK_MASK;
        else if (st_sel)
          o_rd_data <= st_w;
        else if (~lock_act[`FSP_CODE_LOCK_BIT] & ~i_rd_fetch)
          o_rd_data <= `FSP_HIDDEN_WORD;
        else
          o_rd_data <= i_array_data;
      end
    end
  end
endmodule // fsp_flash_status

// File: rtl/fsp_consts.vh
// Constants for the flash status and protection block.
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// Status word bit positions.
`define FSP_POLL_BIT      7
`define FSP_TOG_A_BIT     6
`define FSP_FAIL_BIT      5
`define FSP_WIN_BIT       3
`define FSP_TOG_B_BIT     2
// Lock word layout and reset value.
`define FSP_CODE_LOCK_BIT 15
`define FSP_NUM_BLOCKS    7
`define FSP_LOCK_RESET    16'hFFFF
`define FSP_LOCK_MASK     16'h807F
// Word returned to protected reads.
`define FSP_HIDDEN_WORD   16'h009B
// Timing in ns at a 20 ns clock.
`define FSP_CLK_NS        20
`define FSP_REJECT_NS     100000
`define FSP_WINDOW_NS     96000
`define FSP_REJECT_CYC    (`FSP_REJECT_NS / `FSP_CLK_NS)
`define FSP_WINDOW_CYC    (`FSP_WINDOW_NS / `FSP_CLK_NS)
`endif

// File: rtl/fsp_timer.v
// One-shot down counter used for the reject and erase window times.
`timescale 1ns/10ps
module fsp_timer #(
  parameter integer CYCLES = 16,
  parameter integer W      = 16
) (
  input  wire i_clock,
  input  wire i_srst,
  input  wire i_start,
  input  wire i_stop,
  output reg  o_busy,
  output reg  o_done
);
  reg [W-1:0] cnt_r;
  // Restart wins over stop so a fresh start is never lost.
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    if (i_srst) begin
      cnt_r  <= {W{1'b0}};
      o_busy <= 1'b0;
    end else if (i_start) begin
      cnt_r  <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
      o_busy <= 1'b1;
    end else if (i_stop) begin
      o_busy <= 1'b0;
    end else if (o_busy) begin
      if (cnt_r == {W{1'b0}}) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end else begin
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // fsp_timer

// File: rtl/fsp_lock_store.v
// Protection word store: cleared bits stick, new value takes effect at reset.
`timescale 1ns/10ps
`include "fsp_consts.vh"
module fsp_lock_store (
  input  wire        i_clock,
  input  wire        i_srst,
  input  wire        i_set_we,
  input  wire [15:0] i_set_data,
  output reg  [15:0] o_active,
  output reg  [15:0] o_stored,
  output reg         o_set_err
);
  // The stored word models the non-volatile cells and survives reset;
  // it only starts from all ones at power up.
  initial o_stored = `FSP_LOCK_RESET;
  always @(posedge i_clock) begin
    o_set_err <= 1'b0;
    if (i_set_we) begin
      // Bits may only go to zero; a one over a zero is flagged.
      o_stored  <= o_stored & (i_set_data | ~(`FSP_LOCK_MASK));
      o_set_err <= |(~o_stored & i_set_data & `FSP_LOCK_MASK);
    end
  end
  // The active copy is only refreshed on the cycle after a reset, so a
  // word set while running waits for the next reset.
  reg load_r;
  always @(posedge i_clock) begin
    load_r <= i_srst;
    if (i_srst)
      o_active <= `FSP_LOCK_RESET;
    else if (load_r)
      o_active <= o_stored;
  end
endmodule // fsp_lock_store

// File: tb/fsp_flash_status_monitor.sv
// Concurrent checks on the ports of the flash status block.
`timescale 1ns/10ps
module fsp_flash_status_monitor (
  input wire        i_clock,
  input wire        i_srst,
  input wire        i_rd,
  input wire        i_rd_fetch,
  input wire        i_prog_start,
  input wire        i_erase_conf,
  input wire        i_op_done,
  input wire [15:0] o_rd_data,
  input wire        o_busy,
  input wire        o_suspended,
  input wire        o_refused
);
  // ------------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // A status read during a plain program or erase.
  sequence s_stat_rd;
    i_rd && i_rd_fetch && o_busy && !o_suspended && !i_op_done;
  endsequence
  // Two reads in a row, the first one already past the erase window.
  sequence s_rd_pair;
    s_stat_rd ##1 (s_stat_rd ##0 o_rd_data[3]);
  endsequence
  // A program start taken from idle and not refused.
  sequence s_prog_go;
    i_prog_start && !o_busy && !o_suspended ##1 !o_refused;
  endsequence
  // An accepted erase confirm, then a read inside the window.
  sequence s_erase_rd;
    i_erase_conf && !o_busy && !o_suspended ##1 !o_refused
      ##[0:2] (i_rd && i_rd_fetch);
  endsequence

  a_read_holds: assert property (!i_rd |=> $stable(o_rd_data))
    else $error("Read data moved without a read.");
  a_toggle_a: assert property (
    s_rd_pair |=> o_rd_data[6] != $past(o_rd_data[6]))
    else $error("Toggle A did not flip between reads.");
  a_refuse_pulse: assert property (o_refused |=> !o_refused)
    else $error("Refusal lasted more than one cycle.");
  a_refuse_cause: assert property (
    o_refused |-> $past(i_prog_start) || $past(i_erase_conf))
    else $error("Refusal without a program or erase.");
  a_refuse_keep: assert property (o_refused |-> $stable(o_suspended))
    else $error("Refused command changed the suspend state.");
  a_prog_busy: assert property (s_prog_go |=> o_busy)
    else $error("Accepted program did not raise busy.");
  a_window_low: assert property (s_erase_rd |=> !o_rd_data[3])
    else $error("Window flag high inside the erase window.");
  a_reset_idle: assert property (
    $fell(i_srst) |=> !o_busy && !o_suspended && o_rd_data == 16'h0000)
    else $error("Block not idle after reset.");
endmodule // fsp_flash_status_monitor

bind fsp_flash_status fsp_flash_status_monitor i_mon (
  .i_clock(i_clock), .i_srst(i_srst), .i_rd(i_rd),
  .i_rd_fetch(i_rd_fetch), .i_prog_start(i_prog_start),
  .i_erase_conf(i_erase_conf), .i_op_done(i_op_done),
  .o_rd_data(o_rd_data), .o_busy(o_busy), .o_suspended(o_suspended),
  .o_refused(o_refused));

// File: tb/fsp_cpu_model.sv
// CPU-side model that issues flash reads and command cycles.
`timescale 1ns/10ps
module fsp_cpu_model (
  input  wire        i_clock,
  input  wire [15:0] i_rd_data,
  output reg         o_rd,
  output reg  [2:0]  o_rd_block,
  output reg         o_rd_match,
  output reg         o_rd_fetch,
  output reg  [15:0] o_array_data,
  output reg  [2:0]  o_blk,
  output reg  [15:0] o_prog_data,
  output reg  [15:0] o_prog_old,
  output reg  [15:0] o_lock_data,
  output reg  [8:0]  o_cmd,
  output reg         o_op_fail,
  output reg         o_chip_erase
);
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // All strobes idle low so nothing is taken during reset.
  initial begin
    {o_rd, o_rd_block, o_rd_match, o_rd_fetch, o_array_data} = '0;
    {o_blk, o_prog_data, o_prog_old, o_lock_data, o_cmd} = '0;
    o_op_fail = 1'b0;
    o_chip_erase = 1'b0;
  end

  // One command strobe; bit 8 is the engine's done report.
  task automatic pulse(input int k, input logic [2:0] b);
    @(posedge i_clock);
    o_cmd    <= 9'h001 << k;
    o_blk    <= b;
    @(posedge i_clock);
    o_cmd    <= 9'h000;
    #1;
  endtask

  task automatic prog(input logic [2:0] b, input logic [15:0] d, o);
    @(posedge i_clock);
    o_prog_data <= d;
    o_prog_old  <= o;
    pulse(0, b);
  endtask

  task automatic done(input logic f);
    @(posedge i_clock);
    o_op_fail <= f;
    pulse(8, o_blk);
  endtask

  // Chip erase confirm: the select is held around the confirm strobe.
  task automatic chip(input logic [2:0] b);
    @(posedge i_clock);
    o_chip_erase <= 1'b1;
    pulse(1, b);
    @(posedge i_clock);
    o_chip_erase <= 1'b0;
  endtask

  task automatic lock(input logic [15:0] d);
    @(posedge i_clock);
    o_lock_data <= d;
    pulse(7, o_blk);
  endtask

  // Two back-to-back reads; array data goes stale once released so a
  // late sample cannot pass by luck.
  task automatic rd(input logic [2:0] b, input logic m, f,
                    input logic [15:0] a, output logic [15:0] r1, r2);
    @(posedge i_clock);
    o_rd <= 1'b1;
    {o_rd_block, o_rd_match, o_rd_fetch, o_array_data} <= {b, m, f, a};
    @(posedge i_clock);
    #1 r1 = i_rd_data;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_array_data <= ~a;
    #1 r2 = i_rd_data;
  endtask
endmodule // fsp_cpu_model

// File: tb/flash_status_and_protection_bench.sv
// Self-checking bench for the flash status and protection block.
`timescale 1ns/10ps
module flash_status_and_protection_bench;
  // ------------------------------------------------------------------
  // Clock, reset and wiring
  // ------------------------------------------------------------------
  logic        clock = 1'b0;
  logic        srst  = 1'b1;
  logic [15:0] d1, d2;
  int          err_count = 0;
  int          comparisons = 0;
  wire  [15:0] rd_data, arr, pdat, pold, ldat;
  wire  [8:0]  cmd;
  wire  [2:0]  rblk, blk;
  wire         rd, match, fetch, fail, busy, susp, refused, chip;

  always #10 clock = ~clock;

  fsp_cpu_model i_cpu (.i_clock(clock), .i_rd_data(rd_data), .o_rd(rd),
    .o_rd_block(rblk), .o_rd_match(match), .o_rd_fetch(fetch),
    .o_array_data(arr), .o_blk(blk), .o_prog_data(pdat),
    .o_prog_old(pold), .o_lock_data(ldat), .o_cmd(cmd), .o_op_fail(fail),
    .o_chip_erase(chip));

  // Short reject and window times keep the run brief.
  fsp_flash_status #(.REJECT_CYC(8), .WINDOW_CYC(8)) i_dut (
    .i_clock(clock), .i_srst(srst), .i_rd(rd), .i_rd_block(rblk),
    .i_rd_match(match), .i_rd_fetch(fetch), .i_array_data(arr),
    .i_prog_start(cmd[0]), .i_prog_block(blk), .i_prog_data(pdat),
    .i_prog_old(pold), .i_erase_conf(cmd[1]), .i_erase_block(blk),
    .i_chip_erase(chip), .i_suspend_cmd(cmd[2]), .i_resume_cmd(cmd[3]),
    .i_reset_cmd(cmd[4]), .i_unlock_cmd(cmd[5]), .i_lock_rd_cmd(cmd[6]),
    .i_lock_set(cmd[7]), .i_lock_data(ldat), .i_op_done(cmd[8]),
    .i_op_fail(fail), .o_rd_data(rd_data), .o_busy(busy),
    .o_suspended(susp), .o_refused(refused));

  // ------------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bit_ok(input logic got, exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The lock store keeps its word, so only the logic state restarts.
  task automatic do_reset;
    @(posedge clock) srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_program;
    i_cpu.prog(3'd2, 16'h0080, 16'hFFFF);
    bit_ok(refused, 1'b0);
    i_cpu.rd(3'd2, 1'b1, 1'b1, 16'h5A5A, d1, d2);
    bit_ok(busy, 1'b1);
    bit_ok(d1[7], 1'b0);
    bit_ok(d1[5], 1'b0);
    bit_ok(d2[6], ~d1[6]);
    i_cpu.done(1'b0);
    i_cpu.rd(3'd2, 1'b1, 1'b1, 16'h0080, d1, d2);
    check(d1, 16'h0080);
  endtask

  // A one written over a stored zero must fail even if the engine is happy.
  task automatic t_prog_fail;
    i_cpu.prog(3'd3, 16'h0080, 16'h0000);
    i_cpu.done(1'b0);
    i_cpu.rd(3'd3, 1'b1, 1'b1, 16'hA5A5, d1, d2);
    bit_ok(d1[5], 1'b1);
    i_cpu.pulse(4, 3'd0);
    i_cpu.rd(3'd3, 1'b1, 1'b1, 16'hA5A5, d1, d2);
    check(d1, 16'hA5A5);
  endtask

  task automatic t_erase(input logic f);
    logic a6;
    i_cpu.pulse(1, 3'd1);
    i_cpu.rd(3'd1, 1'b0, 1'b1, 16'hFFFF, d1, d2);
    bit_ok(d1[3], 1'b0);
    repeat (10) @(posedge clock);
    i_cpu.rd(3'd1, 1'b0, 1'b1, 16'hFFFF, d1, d2);
    bit_ok(d1[3], 1'b1);
    bit_ok(d1[7], 1'b0);
    bit_ok(d2[2], ~d1[2]);
    bit_ok(d2[6], ~d1[6]);
    // Suspend flips toggle A once, so the status read of the program inside the suspend repeats this one.
    a6 = d2[6];
    i_cpu.pulse(2, 3'd1);
    i_cpu.rd(3'd1, 1'b0, 1'b1, 16'hFFFF, d1, d2);
    bit_ok(d1[7], 1'b1);
    bit_ok(d1[6] & d2[6], 1'b1);
    bit_ok(d2[2], ~d1[2]);
    bit_ok(susp, 1'b1);
    i_cpu.prog(3'd4, 16'h0000, 16'hFFFF);
    i_cpu.rd(3'd4, 1'b1, 1'b1, 16'h1357, d1, d2);
    bit_ok(d1[2], 1'b1);
    bit_ok(d1[7], 1'b1);
    bit_ok(d1[6], a6);
    i_cpu.done(1'b0);
    i_cpu.pulse(3, 3'd1);
    i_cpu.done(f);
    i_cpu.rd(3'd1, 1'b0, 1'b1, 16'hFFFF, d1, d2);
    if (f) begin
      bit_ok(d1[5], 1'b1);
      bit_ok(d2[2], ~d1[2]);
      i_cpu.pulse(4, 3'd0);
    end else begin
      check(d1, 16'hFFFF);
    end
  endtask

  // Chip erase selects every block; a failed one must raise the fail flag.
  task automatic t_chip;
    i_cpu.chip(3'd6);
    repeat (10) @(posedge clock);
    i_cpu.rd(3'd6, 1'b0, 1'b1, 16'hFFFF, d1, d2);
    bit_ok(d1[7], 1'b0);
    bit_ok(d2[2], ~d1[2]);
    i_cpu.done(1'b1);
    i_cpu.rd(3'd0, 1'b0, 1'b1, 16'h0000, d1, d2);
    bit_ok(d1[5], 1'b1);
    i_cpu.pulse(4, 3'd0);
  endtask

  task automatic t_lock;
    i_cpu.lock(16'h7FFE);
    i_cpu.prog(3'd0, 16'h0000, 16'hFFFF);
    bit_ok(refused, 1'b0);
    i_cpu.done(1'b0);
    i_cpu.pulse(6, 3'd0);
    i_cpu.rd(3'd5, 1'b0, 1'b1, 16'h1234, d1, d2);
    check(d1, 16'h007E);
    i_cpu.pulse(4, 3'd0);
    do_reset;
    i_cpu.prog(3'd0, 16'h0000, 16'hFFFF);
    bit_ok(refused, 1'b1);
    i_cpu.rd(3'd5, 1'b0, 1'b0, 16'h1234, d1, d2);
    check(d1, 16'h009B);
    i_cpu.rd(3'd5, 1'b0, 1'b1, 16'h1234, d1, d2);
    check(d1, 16'h1234);
    i_cpu.pulse(5, 3'd0);
    i_cpu.prog(3'd0, 16'h0000, 16'hFFFF);
    bit_ok(refused, 1'b0);
    i_cpu.done(1'b0);
    do_reset;
    i_cpu.pulse(1, 3'd0);
    bit_ok(refused, 1'b1);
    i_cpu.rd(3'd0, 1'b0, 1'b1, 16'h1234, d1, d2);
    bit_ok(d1[7], 1'b0);
    repeat (10) @(posedge clock);
    i_cpu.rd(3'd0, 1'b0, 1'b1, 16'h1234, d1, d2);
    check(d1, 16'h1234);
  endtask

  // The lock word is written last because it survives every reset.
  initial begin
    do_reset;
    t_program;
    t_prog_fail;
    t_erase(1'b0);
    t_erase(1'b1);
    t_chip;
    t_lock;
    give_verdict;
  end

  // Watchdog far beyond the few hundred cycles the scenarios need.
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
endmodule // flash_status_and_protection_bench
